// [dv/rio_seq_model.sv]
`timescale 1ns/10ps
module rio_seq_model
(
  input  wire logic        sys_clk,
  input  wire logic        ext_mode,
  output logic             cmd_strobe,
  output logic [3:0]       cmd_code,
  output logic [7:0]       cmd_data1,
  output logic [15:0]      cmd_data2,
  output logic             prog_start_req
);
  initial
  begin
    cmd_strobe = 1'b0;
    cmd_code = 4'h0;
    cmd_data1 = 8'h00;
    cmd_data2 = 16'h0000;
    prog_start_req = 1'b0;
  end

  // ----------------------------------------------------------------
  // Command presentation
  // ----------------------------------------------------------------
  // code and fields held under strobe
  task automatic command(input logic stb, input logic [3:0] code,
                         input logic [7:0] d1, input logic [15:0] d2);
    cmd_strobe <= stb;
    cmd_code <= code;
    cmd_data1 <= d1;
    cmd_data2 <= d2;
    @(posedge sys_clk);
    // Released fields carry junk so stale values are never trusted
    cmd_strobe <= 1'b0;
    cmd_code <= ~code;
    cmd_data1 <= ~d1;
    cmd_data2 <= ~d2;
    @(posedge sys_clk);
  endtask

  // Mode switch code with motor/CAL, speed 100 and external bits
  localparam logic [3:0] MODE_SW   = 4'h7;
  localparam logic [7:0] PREP_BITS = 8'h83;

  // preparation done only once external mode shows
  task automatic prepare(output logic done);
    int n;
    n = 0;
    command(1'b1, MODE_SW, PREP_BITS, 16'h0000);
    while (ext_mode !== 1'b1 && n < 20)
    begin
      @(posedge sys_clk);
      n++;
    end
    done = (ext_mode === 1'b1);
  endtask

  task automatic start_req(input logic v);
    prog_start_req <= v;
    @(posedge sys_clk);
  endtask
endmodule

// [dv/testbench.sv]
`timescale 1ns/10ps
module testbench;
  import rio_pkg::*;
  logic        sys_clk, rst, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, img [16], rd;
  logic        cmd_strobe, prog_start_req;
  logic [3:0]  cmd_code;
  logic [7:0]  cmd_data1;
  logic [15:0] cmd_data2, status_out, err_bcd, st;
  logic        pwr_on_done, auto_mode, ext_mode, servo_on, cal_done, teaching;
  logic        start_ack, robot_running, cycle_end, robot_failure;
  logic        robot_warning, resume_ok, safe_start;
  logic        prep_ok;
  logic [8:0]  lv;
  logic [3:0]  ev;
  int          mismatches = 0;
  int          n_checks = 0;
  int          starts [6] = '{128, 129, 250, 255, 384, 504};

  assign lv = {safe_start, resume_ok, robot_running, teaching, cal_done,
               servo_on, ext_mode, auto_mode, pwr_on_done};
  assign ev = {robot_warning, robot_failure, cycle_end, start_ack};

  rio_seq_model seq (.sys_clk(sys_clk), .cmd_strobe(cmd_strobe),
    .cmd_code(cmd_code), .cmd_data1(cmd_data1), .cmd_data2(cmd_data2),
    .prog_start_req(prog_start_req), .ext_mode(ext_mode));

  rio_robot_io dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd_strobe(cmd_strobe), .cmd_code(cmd_code), .cmd_data1(cmd_data1),
    .cmd_data2(cmd_data2), .prog_start_req(prog_start_req),
    .status_out(status_out), .err_bcd(err_bcd), .pwr_on_done(pwr_on_done),
    .auto_mode(auto_mode), .ext_mode(ext_mode), .servo_on(servo_on),
    .cal_done(cal_done), .teaching(teaching), .start_ack(start_ack),
    .robot_running(robot_running), .cycle_end(cycle_end),
    .robot_failure(robot_failure), .robot_warning(robot_warning),
    .resume_ok(resume_ok), .safe_start(safe_start));

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50)
    begin
      mismatches++;
      $display("Error at %0t: bus wait timed out", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic e;
    apb(1'b1, a, d, e);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
                       input logic experr);
    logic e;
    apb(1'b0, a, 32'h0, e);
    chk(rd, exp);
    chk({31'h0, e}, {31'h0, experr});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  function automatic logic [7:0] io8(input int s);
    for (int k = 0; k < 8; k++)
      io8[k] = img[(s + k) / 32][(s + k) % 32];
  endfunction

  task automatic results;
    $display("Checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    #(20000 * 100);
    mismatches++;
    results();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    tick(16);
    rst <= 1'b0;
    tick(1);
    rdchk(OFF_CTRL, 32'h0, 1'b0);
    chk({ev, lv, err_bcd}, 32'h0);
    // one state bit at a time
    for (int i = 0; i < CT_W; i++)
    begin
      wr(OFF_CTRL, 32'h1 << i);
      tick(2);
      chk(lv, 9'h1 << i);
      rdchk(OFF_CTRL, 32'h1 << i, 1'b0);
    end
    wr(OFF_CTRL, 32'h1);
    for (int w = 0; w < 16; w++)
    begin
      img[w] = 32'h5a3c96f0 ^ {4{8'(w * 29)}};
      wr(8'h40 + 8'(4 * w), img[w]);
    end
    // reads across word edges and range ends
    foreach (starts[j])
    begin
      seq.command(1'b1, CMD_IO_READ, 8'(j * 73), 16'(starts[j]));
      tick(1);
      st = {8'h00, io8(starts[j])};
      chk(status_out, st);
      rdchk(OFF_STATUS, {16'h0, st}, 1'b0);
    end
    // no strobe, other codes leave status alone
    seq.command(1'b0, CMD_IO_READ, 8'h00, 16'd136);
    seq.command(1'b1, 4'h4, 8'h00, 16'd200);
    tick(1);
    chk(status_out, st);
    for (int b = 0; b < 2; b++)
    begin
      seq.command(1'b1, CMD_IO_READ, 8'h00, b ? 16'd505 : 16'd127);
      tick(4);
      chk(status_out, st);
      chk({err_bcd, robot_failure, pwr_on_done}, {16'h2034, 2'b10});
      rdchk(OFF_STATUS, {15'h0, 1'b1, st}, 1'b0);
      wr(OFF_EVENT, 32'h1 << EV_CLEAR);
      tick(2);
      chk({err_bcd, robot_failure, pwr_on_done}, {16'h0, 2'b01});
    end
    wr(OFF_ERRNUM, 32'd6174);
    tick(2);
    chk(err_bcd, 16'h6174);
    wr(OFF_ERRNUM, 32'd9999);
    tick(2);
    chk(err_bcd, 16'h9999);
    rdchk(OFF_ERRNUM, 32'd9999, 1'b0);
    for (int f = EV_FAIL; f <= EV_WARN; f++)
    begin
      wr(OFF_EVENT, 32'h1 << f);
      tick(2);
      chk({ev, pwr_on_done}, {4'h1 << f, 1'b0});
      wr(OFF_EVENT, 32'h1 << EV_CLEAR);
      tick(2);
      chk({ev, pwr_on_done}, 5'h01);
    end
    wr(OFF_CTRL, (32'h1 << CT_RUN) | 32'h1);
    wr(OFF_EVENT, 32'h1 << EV_CYCLE);
    tick(2);
    chk(ev, 4'h2);
    seq.start_req(1'b1);
    wr(OFF_EVENT, 32'h1 << EV_STARTED);
    tick(2);
    chk({ev, robot_running}, 5'h03);
    seq.start_req(1'b0);
    tick(2);
    chk({ev, robot_running}, 5'h01);
    // mode switch command while the controller enters external mode
    fork
      seq.prepare(prep_ok);
      wr(OFF_CTRL, 32'h1 | (32'h1 << CT_EXT));
    join
    chk({31'h0, prep_ok}, 32'h1);
    chk(status_out, st);
    // Clock enable low freezes the command path
    clk_en <= 1'b0;
    seq.command(1'b1, CMD_IO_READ, 8'h00, 16'd136);
    chk(status_out, st);
    clk_en <= 1'b1;
    seq.command(1'b1, CMD_IO_READ, 8'h00, 16'd136);
    tick(1);
    st = {8'h00, io8(136)};
    chk(status_out, st);
    // Unmapped place refused, status register read only
    rdchk(8'h20, 32'h0, 1'b1);
    wr(OFF_STATUS, 32'hffff);
    rdchk(OFF_STATUS, {16'h0, st}, 1'b0);
    results();
  end
endmodule

// [rtl/rio_pkg.sv]
package rio_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFF_CTRL    = 8'h00;
  localparam logic [7:0]  OFF_EVENT   = 8'h04;
  localparam logic [7:0]  OFF_ERRNUM  = 8'h08;
  localparam logic [7:0]  OFF_STATUS  = 8'h0c;
  localparam logic [1:0]  IO_REGION   = 2'h1;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int          CT_READY    = 0;
  localparam int          CT_AUTO     = 1;
  localparam int          CT_EXT      = 2;
  localparam int          CT_MOTOR    = 3;
  localparam int          CT_CAL      = 4;
  localparam int          CT_TEACH    = 5;
  localparam int          CT_RUN      = 6;
  localparam int          CT_RESUME   = 7;
  localparam int          CT_SAFE     = 8;
  localparam int          CT_W        = 9;
  localparam logic [8:0]  CTRL_RST    = 9'h000;

  // ----------------------------------------------------------------
  // Event register fields (write one to fire)
  // ----------------------------------------------------------------
  localparam int          EV_STARTED  = 0;
  localparam int          EV_CYCLE    = 1;
  localparam int          EV_FAIL     = 2;
  localparam int          EV_WARN     = 3;
  localparam int          EV_CLEAR    = 4;

  // ----------------------------------------------------------------
  // Command interface
  // ----------------------------------------------------------------
  localparam logic [3:0]  CMD_IO_READ = 4'ha;
  localparam logic [15:0] IO_FIRST    = 16'h0080;
  localparam logic [15:0] IO_LAST     = 16'h01f8;
  localparam logic [13:0] ERR_IO_RNG  = 14'h07f2;
  localparam int          ERR_W       = 14;
  localparam int          IO_WORDS    = 16;

  typedef enum logic [0:0] {
    ACK_IDLE = 1'b0,
    ACK_ON   = 1'b1
  } rio_ack_t;

endpackage

// [rtl/rio_robot_io.sv]
`timescale 1ns/10ps
// Overview of operation
// - Command code 1010 in the four-bit field selects the internal I/O read.
// - The first eight-bit data field is ignored by the internal I/O read.
// - Start number must lie in 128..504; otherwise raise error 2034.
// - Valid read puts eight consecutive I/O bits from start into low byte.
// - Valid read drives the upper status byte to zero.
// - Current error number is shown on the error outputs as BCD digits.
// - Power-on-complete is high while ready for operation preparation; the code holds it low while a failure or warning is latched.
// - Auto-mode output is high exactly while in automatic mode.
// - External-mode output is high exactly while under external control.
// - Servo-on follows motor power, low whenever power is off.
// - Calibration-done is high once calibration completed successfully.
// - Teaching output is high in manual or teach-check mode.
// - Start-acknowledge rises when a requested program starts executing.
// - Robot-running is high while a program executes.
// - Cycle-end is raised when the program completes one cycle.
// - Robot-failure is raised on failures such as servo or program errors.
// - Robot-warning is raised on minor errors, separate from failure.
// - Resume-permitted is high while a continue start is allowed.
// - Safe-start-mode output is high while in safe-start mode.
// - Start-acknowledge drops once the start request is released.
module rio_robot_io
  import rio_pkg::*;
#(
  parameter int WORDS = rio_pkg::IO_WORDS
)
(
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  input  wire logic                      clk_en,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [rio_pkg::ADDR_W-1:0] paddr,
  input  wire logic [rio_pkg::DATA_W-1:0] pwdata,
  output logic      [rio_pkg::DATA_W-1:0] prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      cmd_strobe,
  input  wire logic [3:0]                cmd_code,
  input  wire logic [7:0]                cmd_data1,
  input  wire logic [15:0]               cmd_data2,
  input  wire logic                      prog_start_req,
  output logic      [15:0]               status_out,
  output logic      [15:0]               err_bcd,
  output logic                           pwr_on_done,
  output logic                           auto_mode,
  output logic                           ext_mode,
  output logic                           servo_on,
  output logic                           cal_done,
  output logic                           teaching,
  output logic                           start_ack,
  output logic                           robot_running,
  output logic                           cycle_end,
  output logic                           robot_failure,
  output logic                           robot_warning,
  output logic                           resume_ok,
  output logic                           safe_start
);
  import rio_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (WORDS != 16)
  begin : g_bad_words
    $error("rio_robot_io: WORDS must be 16");
  end

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [15:0] to_bcd(input logic [13:0] bin);
    logic [29:0] sh;
    sh = {16'h0000, bin};
    for (int i = 0; i < 14; i++)
    begin
      for (int d = 0; d < 4; d++)
      begin
        if (sh[14+4*d +: 4] > 4'h4)
          sh[14+4*d +: 4] = sh[14+4*d +: 4] + 4'h3;
      end
      sh = {sh[28:0], 1'b0};
    end
    return sh[29:14];
  endfunction

  function automatic logic in_range(input logic [15:0] n);
    return (n >= IO_FIRST) && (n <= IO_LAST);
  endfunction

  // ----------------------------------------------------------------
  // Internal I/O image and control state
  // ----------------------------------------------------------------
  logic [31:0]     io_mem_q [16];
  logic [CT_W-1:0] ctrl_q;
  logic [ERR_W-1:0] err_num_q;
  logic            fail_q;
  logic            warn_q;
  logic            range_err_q;
  rio_ack_t        ack_q;

  // Wrap on the top word is harmless: start <= 504 never reaches it
  function automatic logic [7:0] io_fetch(input logic [15:0] n);
    logic [3:0]  w;
    logic [63:0] pair;
    w    = n[8:5];
    pair = {io_mem_q[w + 4'h1], io_mem_q[w]};
    return 8'((pair >> n[4:0]));
  endfunction

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic apb_setup;
  logic apb_wr;
  logic wr_ctrl;
  logic wr_event;
  logic wr_err;
  logic wr_io;
  logic addr_ok;
  logic [DATA_W-1:0] rd_mux;

  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pready && pwrite;
  assign wr_ctrl   = apb_wr && (paddr == OFF_CTRL);
  assign wr_event  = apb_wr && (paddr == OFF_EVENT);
  assign wr_err    = apb_wr && (paddr == OFF_ERRNUM);
  assign wr_io     = apb_wr && (paddr[7:6] == IO_REGION)
                     && (paddr[1:0] == 2'h0);

  always_comb
  begin
    addr_ok = 1'b1;
    rd_mux  = '0;
    if (paddr[7:6] == IO_REGION && paddr[1:0] == 2'h0)
      rd_mux = io_mem_q[paddr[5:2]];
    else
    begin
      unique case (paddr)
        OFF_CTRL:   rd_mux = 32'(ctrl_q);
        OFF_EVENT:  rd_mux = '0;
        OFF_ERRNUM: rd_mux = 32'(err_num_q);
        OFF_STATUS: rd_mux = {15'h0000, range_err_q, status_out};
        default:    addr_ok = 1'b0;
      endcase
    end
  end

  // Zero wait states; read data is latched in the setup cycle
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (clk_en)
    begin
      pready <= 1'b1;
      if (apb_setup)
      begin
        prdata  <= pwrite ? '0 : rd_mux;
        pslverr <= !addr_ok;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      ctrl_q <= CTRL_RST;
    else if (clk_en && wr_ctrl)
      ctrl_q <= pwdata[CT_W-1:0];
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < 16; i++)
        io_mem_q[i] <= '0;
    end
    else if (clk_en && wr_io)
      io_mem_q[paddr[5:2]] <= pwdata;
  end

  // ----------------------------------------------------------------
  // Command interpreter
  // ----------------------------------------------------------------
  logic io_cmd;
  logic io_ok;
  logic io_bad;

  assign io_cmd = cmd_strobe && (cmd_code == CMD_IO_READ);
  assign io_ok  = io_cmd && in_range(cmd_data2);
  assign io_bad = io_cmd && !in_range(cmd_data2);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      status_out <= 16'h0000;
    else if (clk_en && io_ok)
      status_out <= {8'h00, io_fetch(cmd_data2)};
  end

  function automatic logic wr_event_clr();
    return wr_event && pwdata[EV_CLEAR];
  endfunction

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      range_err_q <= 1'b0;
    else if (clk_en)
      range_err_q <= io_bad || (range_err_q && !wr_event_clr());
  end

  // ----------------------------------------------------------------
  // Error number and sticky failure and warning
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      err_num_q <= '0;
    else if (clk_en)
    begin
      if (io_bad)
        err_num_q <= ERR_IO_RNG;
      else if (wr_err)
        err_num_q <= pwdata[ERR_W-1:0];
      else if (wr_event_clr())
        err_num_q <= '0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      fail_q <= 1'b0;
      warn_q <= 1'b0;
    end
    else if (clk_en)
    begin
      fail_q <= io_bad || (wr_event && pwdata[EV_FAIL])
                || (fail_q && !wr_event_clr());
      warn_q <= (wr_event && pwdata[EV_WARN])
                || (warn_q && !wr_event_clr());
    end
  end

  // ----------------------------------------------------------------
  // Program start handshake
  // ----------------------------------------------------------------
  logic start_evt;
  assign start_evt = wr_event && pwdata[EV_STARTED];

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      ack_q <= ACK_IDLE;
    else if (clk_en)
    begin
      unique case (ack_q)
        ACK_IDLE: if (start_evt && prog_start_req) ack_q <= ACK_ON;
        ACK_ON:   if (!prog_start_req) ack_q <= ACK_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // System status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pwr_on_done   <= 1'b0;
      auto_mode     <= 1'b0;
      ext_mode      <= 1'b0;
      servo_on      <= 1'b0;
      cal_done      <= 1'b0;
      teaching      <= 1'b0;
      start_ack     <= 1'b0;
      robot_running <= 1'b0;
      cycle_end     <= 1'b0;
      robot_failure <= 1'b0;
      robot_warning <= 1'b0;
      resume_ok     <= 1'b0;
      safe_start    <= 1'b0;
      err_bcd       <= 16'h0000;
    end
    else if (clk_en)
    begin
      pwr_on_done   <= ctrl_q[CT_READY] && !fail_q && !warn_q;
      auto_mode     <= ctrl_q[CT_AUTO];
      ext_mode      <= ctrl_q[CT_EXT];
      servo_on      <= ctrl_q[CT_MOTOR];
      cal_done      <= ctrl_q[CT_CAL];
      teaching      <= ctrl_q[CT_TEACH];
      start_ack     <= (ack_q == ACK_ON) && prog_start_req;
      robot_running <= ctrl_q[CT_RUN];
      // cycle end, cleared by next start
      cycle_end     <= (wr_event && pwdata[EV_CYCLE])
                       || (cycle_end && !start_evt);
      robot_failure <= fail_q;
      robot_warning <= warn_q;
      resume_ok     <= ctrl_q[CT_RESUME];
      safe_start    <= ctrl_q[CT_SAFE];
      err_bcd       <= to_bcd(err_num_q);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_good_read;
    clk_en && io_ok;
  endsequence

  sequence s_bad_read;
    clk_en && io_bad;
  endsequence

  a_read_low_byte: assert property (@(posedge sys_clk) disable iff (rst)
    s_good_read |=> status_out[7:0] == $past(io_fetch(cmd_data2)))
    else $error("I/O read low byte wrong");

  a_read_upper_zero: assert property (@(posedge sys_clk) disable iff (rst)
    s_good_read |=> status_out[15:8] == 8'h00)
    else $error("I/O read upper byte not zero");

  a_range_error: assert property (@(posedge sys_clk) disable iff (rst)
    s_bad_read |=> fail_q && err_num_q == ERR_IO_RNG
      && $stable(status_out) ##1 (!clk_en || robot_failure))
    else $error("Out of range start not flagged");

  a_error_bcd: assert property (@(posedge sys_clk) disable iff (rst)
    s_bad_read ##1 clk_en |=> err_bcd == 16'h2034)
    else $error("Error number not shown as BCD");

  a_strobe_hold: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && !cmd_strobe |=> $stable(status_out))
    else $error("Status changed without strobe");

  a_servo_follow: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en |=> servo_on == $past(ctrl_q[CT_MOTOR]))
    else $error("Servo output does not follow motor");

  a_ack_drop: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && !prog_start_req |=> !start_ack)
    else $error("Start acknowledge held after release");

  a_ack_rise: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && start_evt && prog_start_req && ack_q == ACK_IDLE
      ##1 clk_en && prog_start_req |=> start_ack)
    else $error("Start acknowledge missing");

  a_pwr_fault_off: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && (fail_q || warn_q) |=> !pwr_on_done)
    else $error("Power-on-complete high during fault");

endmodule
